/* hdl/sbs_pkg.sv */
/*
  Shared constants and types of the SRAM boundary scan test port.
  Assumes the test clock and the system clock are unrelated.
*/
`default_nettype none

package sbs_pkg;

  // ==========================================================================
  // Register widths
  localparam int IR_W  = 3;
  localparam int ID_W  = 32;
  localparam int BSR_W = 109;

  // ==========================================================================
  // Opcodes
  localparam logic [IR_W-1:0] OP_EXTEST   = 3'h0;
  localparam logic [IR_W-1:0] OP_IDCODE   = 3'h1;
  localparam logic [IR_W-1:0] OP_SAMPLE_Z = 3'h2;
  localparam logic [IR_W-1:0] OP_SAMPLE   = 3'h4;
  localparam logic [IR_W-1:0] OP_BYPASS   = 3'h7;

  // Value captured into the opcode shift path
  localparam logic [IR_W-1:0] IR_CAPTURE  = 3'h1;

  // ==========================================================================
  // Reset values
  localparam logic [IR_W-1:0]  IR_RESET   = OP_IDCODE;
  localparam logic [BSR_W-1:0] BSR_RESET  = 109'h0;

  // ==========================================================================
  // Timing
  localparam int TLR_TMS_HIGH   = 5;
  localparam int CLK_PERIOD_NS  = 40;
  localparam int CAP_SETUP_NS   = 5;
  localparam int CAP_HOLD_NS    = 5;
  localparam int CAP_QUIET_CYC  =
    ((CAP_SETUP_NS + CAP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
    (CAP_SETUP_NS + CAP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // Types
  typedef enum logic [3:0] {
    ST_TLR, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR,
    ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
    ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } sbs_state_t;

  typedef enum logic [1:0] {
    SEL_BYPASS, SEL_ID, SEL_BSR
  } sbs_dr_sel_t;

endpackage : sbs_pkg

`default_nettype wire

/* hdl/sbs_tap_fsm.sv */
/*
  Sixteen-state test port controller, stepped by TMS on rising TCK.
  Assumes a reset already aligned to the test clock.
*/
`default_nettype none

module sbs_tap_fsm
  import sbs_pkg::*;
(
  // Test clock and reset
  input  wire logic       tck,
  input  wire logic       rst,
  // Mode select and state
  input  wire logic       tms,
  output var sbs_state_t  state
);

  // ==========================================================================
  // Next state
  function automatic sbs_state_t step(input sbs_state_t s, input logic m);
    unique case (s)
      ST_TLR:      step = m ? ST_TLR      : ST_IDLE;
      ST_IDLE:     step = m ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_DR:   step = m ? ST_SEL_IR   : ST_CAP_DR;
      ST_CAP_DR:   step = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: step = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: step = m ? ST_UPD_DR   : ST_PAUSE_DR;
      ST_PAUSE_DR: step = m ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: step = m ? ST_UPD_DR   : ST_SHIFT_DR;
      ST_UPD_DR:   step = m ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_IR:   step = m ? ST_TLR      : ST_CAP_IR;
      ST_CAP_IR:   step = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: step = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: step = m ? ST_UPD_IR   : ST_PAUSE_IR;
      ST_PAUSE_IR: step = m ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: step = m ? ST_UPD_IR   : ST_SHIFT_IR;
      ST_UPD_IR:   step = m ? ST_SEL_DR   : ST_IDLE;
    endcase
  endfunction : step

  // ==========================================================================
  // State register
  always_ff @(posedge tck or posedge rst)
  begin
    if (rst)
      state <= ST_TLR;
    else
      state <= step(state, tms);
  end

  // ==========================================================================
  // Checks
  property p_tms_reset;
    @(posedge tck) disable iff (rst)
    tms [*5] |=> (state == ST_TLR);
  endproperty
  a_tms_reset: assert property (p_tms_reset) else $error("five TMS highs did not reach reset");

endmodule : sbs_tap_fsm

`default_nettype wire

/* hdl/sbs_tap.sv */
/*
  Boundary scan test port of a synchronous SRAM: opcode, bypass, ID and
  boundary scan paths on TCK, plus memory-side controls on CLK.
  Assumes pad levels arrive unsynchronised and TMS/TDI change on falling TCK.
*/
`default_nettype none

module sbs_tap
  import sbs_pkg::*;
#(
  parameter logic [ID_W-1:0] ID_CODE = 32'h0000_0001  // Arbitrary identity value
)
(
  // System clock and power-up reset
  input  wire logic             CLK,
  input  wire logic             SYS_RST,
  // Test port
  input  wire logic             TCK,
  input  wire logic             TMS,
  input  wire logic             TDI,
  output logic                  TDO,
  output logic                  TDO_OE_N,
  // Pads
  input  wire logic [BSR_W-1:0] PAD_IN,
  output logic      [BSR_W-1:0] PAD_DRV,
  output logic                  PAD_DRV_OE_N,
  // Memory core controls
  output logic                  MEM_OUT_HIZ,
  output logic                  MEM_HALT
);

  // ==========================================================================
  // Declarations
  logic             rst_meta;
  logic             rst_tck;
  sbs_state_t       state;
  logic [IR_W-1:0]  ir_shift;
  logic [IR_W-1:0]  opcode_register;
  logic             single_bit_shortcut;
  logic [ID_W-1:0]  id_shift;
  logic [BSR_W-1:0] scan_cell_chain;
  logic [BSR_W-1:0] pad_meta;
  logic [BSR_W-1:0] pad_sync;
  logic             hiz_tck;
  logic             hiz_meta;
  logic             hiz_sync;
  logic             ext_meta;
  logic             ext_sync;
  sbs_dr_sel_t      dr_sel;

  // Path selection; unused codes fall back to the shortcut
  function automatic sbs_dr_sel_t sel_of(input logic [IR_W-1:0] op);
    unique case (op)
      OP_IDCODE:                       sel_of = SEL_ID;
      OP_EXTEST, OP_SAMPLE_Z, OP_SAMPLE: sel_of = SEL_BSR;
      default:                         sel_of = SEL_BYPASS;
    endcase
  endfunction : sel_of
  assign dr_sel = sel_of(opcode_register);

  // ==========================================================================
  // Test clock reset, asserted at once and released on TCK
  always_ff @(posedge TCK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      rst_meta <= 1'b1;
      rst_tck  <= 1'b1;
    end
    else
    begin
      rst_meta <= 1'b0;
      rst_tck  <= rst_meta;
    end
  end

  sbs_tap_fsm i_sbs_tap_fsm (
    .tck   (TCK),
    .rst   (rst_tck),
    .tms   (TMS),
    .state (state)
  );

  // ==========================================================================
  // Opcode path
  always_ff @(posedge TCK or posedge rst_tck)
  begin
    if (rst_tck)
    begin
      ir_shift        <= IR_CAPTURE;
      opcode_register <= IR_RESET;
    end
    else
    begin
      if (state == ST_CAP_IR)
        ir_shift <= IR_CAPTURE;
      else if (state == ST_SHIFT_IR)
        ir_shift <= {TDI, ir_shift[IR_W-1:1]};
      if (state == ST_TLR)
        opcode_register <= IR_RESET;
      else if (state == ST_UPD_IR)
        opcode_register <= ir_shift;
    end
  end

  // ==========================================================================
  // Data paths
  always_ff @(posedge TCK or posedge rst_tck)
  begin
    if (rst_tck)
    begin
      single_bit_shortcut <= 1'b0;
      id_shift            <= ID_CODE;
      scan_cell_chain     <= BSR_RESET;
    end
    else if (state == ST_CAP_DR)
    begin
      single_bit_shortcut <= 1'b0;
      if (dr_sel == SEL_ID)
        id_shift <= ID_CODE;
      if (dr_sel == SEL_BSR)
        scan_cell_chain <= pad_sync;
    end
    else if (state == ST_SHIFT_DR)
    begin
      if (dr_sel == SEL_BYPASS)
        single_bit_shortcut <= TDI;
      if (dr_sel == SEL_ID)
        id_shift <= {TDI, id_shift[ID_W-1:1]};
      if (dr_sel == SEL_BSR)
        scan_cell_chain <= {TDI, scan_cell_chain[BSR_W-1:1]};
    end
  end

  // Pad levels are asynchronous to TCK; a capture may catch a transition
  always_ff @(posedge TCK or posedge rst_tck)
  begin
    if (rst_tck)
    begin
      pad_meta <= BSR_RESET;
      pad_sync <= BSR_RESET;
    end
    else
    begin
      pad_meta <= PAD_IN;
      pad_sync <= pad_meta;
    end
  end

  // ==========================================================================
  // Pad drive: preload/extest update and driver enable
  always_ff @(posedge TCK or posedge rst_tck)
  begin
    if (rst_tck)
      PAD_DRV <= BSR_RESET;
    else if (state == ST_UPD_DR && (opcode_register == OP_SAMPLE || opcode_register == OP_EXTEST))
      PAD_DRV <= scan_cell_chain;
  end
  always_ff @(posedge TCK or posedge rst_tck)
  begin
    if (rst_tck)
    begin
      PAD_DRV_OE_N <= 1'b1;
      hiz_tck      <= 1'b0;
    end
    else if (state == ST_TLR)
    begin
      PAD_DRV_OE_N <= 1'b1;
      hiz_tck      <= 1'b0;
    end
    else if (state == ST_UPD_IR)
    begin
      PAD_DRV_OE_N <= (ir_shift != OP_EXTEST);
      hiz_tck      <= (ir_shift == OP_SAMPLE_Z);
    end
  end

  // ==========================================================================
  // TDO on falling TCK
  always_ff @(negedge TCK or posedge rst_tck)
  begin
    if (rst_tck)
    begin
      TDO      <= 1'b0;
      TDO_OE_N <= 1'b1;
    end
    else
    begin
      TDO_OE_N <= !(state == ST_SHIFT_IR || state == ST_SHIFT_DR);
      if (state == ST_SHIFT_IR)
        TDO <= ir_shift[0];
      else if (dr_sel == SEL_ID)
        TDO <= id_shift[0];
      else if (dr_sel == SEL_BSR)
        TDO <= scan_cell_chain[0];
      else
        TDO <= single_bit_shortcut;
    end
  end

  // ==========================================================================
  // Memory side controls on CLK
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      hiz_meta    <= 1'b0;
      hiz_sync    <= 1'b0;
      ext_meta    <= 1'b0;
      ext_sync    <= 1'b0;
      MEM_OUT_HIZ <= 1'b0;
      MEM_HALT    <= 1'b0;
    end
    else
    begin
      hiz_meta    <= hiz_tck;
      hiz_sync    <= hiz_meta;
      ext_meta    <= !PAD_DRV_OE_N;
      ext_sync    <= ext_meta;
      MEM_OUT_HIZ <= hiz_sync | ext_sync;
      if (ext_sync)
        MEM_HALT <= 1'b1;
    end
  end

  // ==========================================================================
  // Checks
  property p_extest_apply;
    @(posedge TCK) disable iff (rst_tck)
    (state == ST_UPD_DR && opcode_register == OP_EXTEST) |=> (PAD_DRV == $past(scan_cell_chain));
  endproperty
  a_extest_apply: assert property (p_extest_apply) else $error("extest update not applied");
  property p_extest_drive;
    @(posedge TCK) disable iff (rst_tck)
    (state == ST_UPD_IR && ir_shift == OP_EXTEST) |=> !PAD_DRV_OE_N;
  endproperty
  a_extest_drive: assert property (p_extest_drive) else $error("drivers off after extest");
  property p_id_capture;
    @(posedge TCK) disable iff (rst_tck)
    (state == ST_CAP_DR && opcode_register == OP_IDCODE) |=> (id_shift == ID_CODE);
  endproperty
  a_id_capture: assert property (p_id_capture) else $error("ID not captured");
  property p_reset_opcode;
    @(posedge TCK) disable iff (rst_tck)
    (state == ST_TLR) |=> (opcode_register == OP_IDCODE);
  endproperty
  a_reset_opcode: assert property (p_reset_opcode) else $error("reset opcode not ID");
  property p_hiz_quiet;
    @(posedge TCK) disable iff (rst_tck)
    (opcode_register == OP_SAMPLE_Z) |-> (PAD_DRV_OE_N && hiz_tck);
  endproperty
  a_hiz_quiet: assert property (p_hiz_quiet) else $error("outputs driven in high-Z sample");
  property p_chain_capture;
    @(posedge TCK) disable iff (rst_tck)
    (state == ST_CAP_DR && (opcode_register == OP_SAMPLE_Z || opcode_register == OP_SAMPLE))
      |=> (scan_cell_chain == $past(pad_sync));
  endproperty
  a_chain_capture: assert property (p_chain_capture) else $error("pad capture wrong");
  property p_shortcut;
    @(posedge TCK) disable iff (rst_tck)
    (state == ST_SHIFT_DR && opcode_register == OP_BYPASS) |=> (single_bit_shortcut == $past(TDI));
  endproperty
  a_shortcut: assert property (p_shortcut) else $error("shortcut did not take TDI");
  property p_tdo_ir;
    @(posedge TCK) disable iff (rst_tck)
    (state == ST_SHIFT_IR && $past(state) == ST_SHIFT_IR) |-> (TDO == ir_shift[0] && !TDO_OE_N);
  endproperty
  a_tdo_ir: assert property (p_tdo_ir) else $error("TDO not updated on falling edge");
  property p_opcode_load;
    @(posedge TCK) disable iff (rst_tck)
    (state == ST_UPD_IR) |=> (opcode_register == $past(ir_shift));
  endproperty
  a_opcode_load: assert property (p_opcode_load) else $error("opcode not loaded");
  property p_halt_sticky;
    @(posedge CLK) disable iff (SYS_RST)
    MEM_HALT |=> MEM_HALT;
  endproperty
  a_halt_sticky: assert property (p_halt_sticky) else $error("halt cleared without reset");

endmodule : sbs_tap

`default_nettype wire

/* dv/sbs_jtag_ctl.sv */
/*
  Behavioural boundary scan controller facing the test port.
  Assumes the bench calls its tasks one at a time; TCK stands still between them.
*/
`default_nettype none

module sbs_jtag_ctl
  import sbs_pkg::*;
(
  // Test port
  output logic             tck,
  output logic             tms,
  output logic             tdi,
  input  wire logic        tdo,
  // Scan result
  output logic [BSR_W-1:0] res,
  output logic             res_vld
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    res = '0;
    res_vld = 1'b0;
  end

  // ==========================================================================
  // One TCK cycle of 6 ns
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #1.5;
    q = tdo;
    tck = 1'b1;
    #3;
    tck = 1'b0;
    #1.5;
  endtask : step

  // State move; TDI toggles since nothing samples it here
  task automatic move(input logic m);
    logic q;
    step(m, ~tdi, q);
  endtask : move

  // Five TMS highs reach Test-Logic-Reset from anywhere
  task automatic tlr();
    repeat (TLR_TMS_HIGH) move(1'b1);
  endtask : tlr

  // ==========================================================================
  // Full IR or DR scan from Idle or Test-Logic-Reset, back to Idle
  task automatic scan(input logic ir, input int n, input logic [BSR_W-1:0] din);
    logic             q;
    logic [BSR_W-1:0] dout;
    dout = '0;
    move(1'b0);
    move(1'b0);
    move(1'b1);
    if (ir)
      move(1'b1);
    move(1'b0);
    move(1'b0);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    move(1'b1);
    move(1'b0);
    res = dout;
    res_vld = 1'b1;
    #1;
    res_vld = 1'b0;
  endtask : scan

endmodule : sbs_jtag_ctl

`default_nettype wire

/* dv/sbs_tap_bench.sv */
/*
  Self-checking bench of the SRAM boundary scan test port.
  Assumes the controller model drives the test port and scan results queue up in order.
*/
`default_nettype none

module sbs_tap_bench
  import sbs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [ID_W-1:0] ID_VAL = 32'h0C3A_5001;  // Arbitrary identity value

  logic             CLK, SYS_RST, TCK, TMS, TDI, TDO, TDO_OE_N, tdo_w;
  logic             PAD_DRV_OE_N, MEM_OUT_HIZ, MEM_HALT, res_vld;
  logic [BSR_W-1:0] PAD_IN, PAD_DRV, res, din, pre;
  logic [BSR_W-1:0] exp_q[$];
  logic [31:0]      seed;
  int               error_cnt, n_compared;

  // Released TDO shows the inverse of its last level
  assign tdo_w = TDO_OE_N ? ~TDO : TDO;

  sbs_tap #(.ID_CODE(ID_VAL)) i_sbs_tap (.CLK(CLK), .SYS_RST(SYS_RST), .TCK(TCK), .TMS(TMS), .TDI(TDI),
    .TDO(TDO), .TDO_OE_N(TDO_OE_N), .PAD_IN(PAD_IN), .PAD_DRV(PAD_DRV), .PAD_DRV_OE_N(PAD_DRV_OE_N),
    .MEM_OUT_HIZ(MEM_OUT_HIZ), .MEM_HALT(MEM_HALT));
  sbs_jtag_ctl i_sbs_jtag_ctl (.tck(TCK), .tms(TMS), .tdi(TDI), .tdo(tdo_w), .res(res), .res_vld(res_vld));

  always #20 CLK = ~CLK;

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic [BSR_W-1:0] rnd();
    logic [127:0] w;
    w = {xs(), xs(), xs(), xs()};
    return w[BSR_W-1:0];
  endfunction : rnd

  task automatic chk(input logic [BSR_W-1:0] g, input logic [BSR_W-1:0] e);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic lvl(input logic g, input logic e);
    chk(BSR_W'(g), BSR_W'(e));
  endtask : lvl

  task automatic scan(input logic ir, input int n, input logic [BSR_W-1:0] d, input logic [BSR_W-1:0] e);
    exp_q.push_back(e);
    i_sbs_jtag_ctl.scan(ir, n, d);
  endtask : scan

  task automatic clk_wait();
    repeat (5) @(posedge CLK);
    #1;
  endtask : clk_wait

  task automatic summarize();
    if (exp_q.size() != 0)
      error_cnt++;
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  // ==========================================================================
  // Result watcher
  always @(posedge res_vld)
  begin
    if (exp_q.size() > 0)
      chk(res, exp_q.pop_front());
    else
      chk(res, ~res);
  end

  initial
  begin
    repeat (20000) @(posedge CLK);
    error_cnt++;
    summarize();
  end

  // ==========================================================================
  // Main sequence
  initial
  begin
    CLK = 1'b0;
    SYS_RST = 1'b0;
    PAD_IN = '0;
    seed = 32'h015A;
    error_cnt = 0;
    n_compared = 0;
    #1;
    SYS_RST = 1'b1;
    repeat (8) @(posedge CLK);
    #1;
    lvl(TDO_OE_N, 1'b1);
    lvl(PAD_DRV_OE_N, 1'b1);
    chk(PAD_DRV, '0);
    SYS_RST = 1'b0;
    repeat (4) i_sbs_jtag_ctl.move(1'b1);
    scan(1'b0, ID_W, rnd(), BSR_W'(ID_VAL));
    $display("Test identity after power-up done");

    repeat (4)
    begin
      scan(1'b1, IR_W, BSR_W'(OP_BYPASS), BSR_W'(IR_CAPTURE));
      din = rnd();
      scan(1'b0, 8, din, BSR_W'({din[6:0], 1'b0}));
    end
    $display("Test bypass done");

    clk_wait();
    PAD_IN = rnd();
    pre = rnd();
    scan(1'b1, IR_W, BSR_W'(OP_SAMPLE), BSR_W'(IR_CAPTURE));
    scan(1'b0, BSR_W, pre, PAD_IN);
    chk(PAD_DRV, pre);
    lvl(PAD_DRV_OE_N, 1'b1);
    $display("Test sample and preload done");

    scan(1'b1, IR_W, BSR_W'(OP_SAMPLE_Z), BSR_W'(IR_CAPTURE));
    clk_wait();
    lvl(MEM_OUT_HIZ, 1'b1);
    PAD_IN = rnd();
    scan(1'b0, BSR_W, rnd(), PAD_IN);
    chk(PAD_DRV, pre);
    lvl(PAD_DRV_OE_N, 1'b1);
    $display("Test high-Z sample done");

    scan(1'b1, IR_W, BSR_W'(OP_EXTEST), BSR_W'(IR_CAPTURE));
    lvl(PAD_DRV_OE_N, 1'b0);
    chk(PAD_DRV, pre);
    clk_wait();
    lvl(MEM_HALT, 1'b1);
    PAD_IN = rnd();
    din = rnd();
    scan(1'b0, BSR_W, din, PAD_IN);
    chk(PAD_DRV, din);
    $display("Test external test done");

    i_sbs_jtag_ctl.move(1'b1);
    i_sbs_jtag_ctl.move(1'b0);
    i_sbs_jtag_ctl.move(1'b0);
    i_sbs_jtag_ctl.tlr();
    i_sbs_jtag_ctl.move(1'b1);
    lvl(PAD_DRV_OE_N, 1'b1);
    scan(1'b0, ID_W, rnd(), BSR_W'(ID_VAL));
    clk_wait();
    lvl(MEM_OUT_HIZ, 1'b0);
    lvl(MEM_HALT, 1'b1);
    $display("Test reset by TMS done");

    clk_wait();
    SYS_RST = 1'b1;
    clk_wait();
    lvl(MEM_HALT, 1'b0);
    SYS_RST = 1'b0;
    repeat (4) i_sbs_jtag_ctl.move(1'b1);
    scan(1'b0, ID_W, rnd(), BSR_W'(ID_VAL));
    $display("Test second power-up done");
    summarize();
  end

endmodule : sbs_tap_bench

`default_nettype wire
